/* File: pkg/hbi_pkg.sv */
// Purpose: constants, coefficient table and shared arithmetic for the half-band interpolator
// Assumes: CLK runs at four times the input data rate; samples are 14-bit offset binary
// Notes:   coefficients are Q15; the centre tap is 0.5, applied with the x2 interpolation gain
package hbi_pkg;

    localparam int DATA_W  = 14;
    localparam int COEF_W  = 16;
    localparam int ACC_W   = 36;
    localparam int NTAPS   = 43;
    localparam int CENTRE  = 21;
    localparam int NPAIRS  = 11;
    localparam int DLY_LEN = 22;
    localparam int CENTRE_DLY = 10;
    localparam int FRAC_W  = 15;

    localparam logic [DATA_W-1:0] MIDSCALE = 14'h2000;
    localparam logic [1:0]        PH_TAKE  = 2'h0;
    localparam logic [1:0]        PH_CALC  = 2'h1;
    localparam logic [1:0]        PH_SLOT0 = 2'h2;
    localparam logic [4:0]        FLUSH_SAMPLES = 5'h16;
    localparam logic [ACC_W-1:0]  ROUND_HALF = 36'h000004000;

    // side taps, innermost pair first; even-indexed neighbours of the centre are zero
    localparam logic signed [COEF_W-1:0] COEF [0:NPAIRS-1] = '{
        16'sh5158, -16'sh1AF4, 16'sh0F8C, -16'sh0A3C, 16'sh071C, -16'sh0500,
        16'sh0384, -16'sh0258, 16'sh017C, -16'sh00DC, 16'sh0064
    };

    function automatic logic signed [DATA_W-1:0] to_signed(input logic [DATA_W-1:0] ob);
        to_signed = {~ob[DATA_W-1], ob[DATA_W-2:0]};
    endfunction

    // round half up, saturate to 14 bits, return offset binary like the midscale code
    function automatic logic [DATA_W-1:0] round_sat(input logic signed [ACC_W-1:0] acc);
        logic signed [ACC_W-1:0] r;
        logic signed [ACC_W-1:0] q;
        r = acc + $signed(ROUND_HALF);
        q = r >>> FRAC_W;
        if (q > $signed(36'h000001FFF)) begin
            round_sat = 14'h3FFF;
        end else if (q < -$signed(36'h000002000)) begin
            round_sat = 14'h0000;
        end else begin
            round_sat = {~q[DATA_W-1], q[DATA_W-2:0]};
        end
    endfunction

endpackage

/* File: src/zero_stuff_mux.sv */
// Purpose: output multiplexer that interleaves filter samples with the midscale code
// Assumes: slot advances once per CLK, four slots per input sample
// Notes:   the midscale word lives in its own register, never recomputed
`timescale 1ns/1ps
module zero_stuff_mux
    import hbi_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // filter side
    input  wire logic [DATA_W-1:0] even_smp,
    input  wire logic [DATA_W-1:0] odd_smp,
    input  wire logic              smp_ok,
    input  wire logic [1:0]        slot,
    input  wire logic              zero_ins,
    // converter side
    output logic      [DATA_W-1:0] dac_data,
    output logic                   dac_valid
);

    logic [DATA_W-1:0] mid_r;
    logic [DATA_W-1:0] dac_r;
    logic              vld_r;
    wire               stuff_slot = slot[0] & zero_ins;
    wire [DATA_W-1:0]  filt_pick  = slot[1] ? odd_smp : even_smp;
    // flushing output parks at midscale so the converter sees no stale data
    wire [DATA_W-1:0]  dac_nxt    = (stuff_slot | ~smp_ok) ? mid_r : filt_pick;

    always_ff @(posedge clk) begin
        if (srst) begin
            mid_r <= MIDSCALE;
            dac_r <= MIDSCALE;
            vld_r <= 1'b0;
        end else begin
            mid_r <= MIDSCALE;
            dac_r <= dac_nxt;
            vld_r <= smp_ok;
        end
    end

    assign dac_data  = dac_r;
    assign dac_valid = vld_r;

endmodule // zero_stuff_mux

/* File: src/halfband_interp_zero_stuff.sv */
// Purpose: 2x half-band interpolator with low/high-pass select and optional zero insertion
// Assumes: CLK is the 4x clock; the source presents one word per DATA_TAKE pulse
// Notes:   polyphase form, so only the 11 symmetric pairs need multipliers
// Functional notes
// - interpolator is a symmetric half-band FIR with 43 taps
// - response select low gives low-pass, high gives high-pass
// - two filter outputs produced for every input sample
// - high-pass negates only the centre tap; other even taps are zero
// - high-pass equals low-pass response mixed with half-rate alternating sign
// - zero insertion on while zero-insert enable input held high
// - with insertion on, midscale code follows every filter sample
// - insertion is a mux at 4x rate between filter output and midscale register
// - high-pass plus insertion equals mixing with square wave at data rate
// - input word captured on the data-rate edge; source aligns data to it
`timescale 1ns/1ps
module halfband_interp_zero_stuff
    import hbi_pkg::*;
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              SRST,
    // sample source
    input  wire logic [DATA_W-1:0] DATA_IN,
    output logic                   DATA_TAKE,
    // mode pins
    input  wire logic              FILTER_RESPONSE_SELECT,
    input  wire logic              ZERO_INSERT_ENABLE,
    // converter side
    output logic      [DATA_W-1:0] DAC_DATA,
    output logic                   DAC_VALID
);

    logic        [1:0]        phase_r;
    logic signed [DATA_W-1:0] dly_r [0:DLY_LEN-1];
    logic        [DATA_W-1:0] even_r;
    logic        [DATA_W-1:0] odd_r;
    logic                     hp_r;
    logic                     zs_r;
    logic        [4:0]        flush_r;
    logic signed [ACC_W-1:0]  pair_acc;
    logic signed [ACC_W-1:0]  centre_acc;

    wire take      = (phase_r == PH_TAKE);
    wire calc      = (phase_r == PH_CALC);
    wire mode_chg  = (hp_r != FILTER_RESPONSE_SELECT) | (zs_r != ZERO_INSERT_ENABLE);
    wire flushed   = (flush_r == FLUSH_SAMPLES);
    wire [1:0] slot = phase_r - PH_SLOT0;

    // only 22 nonzero side taps plus the centre survive out of 43
    always_comb begin
        pair_acc = '0;
        for (int k = 0; k < NPAIRS; k++) begin
            pair_acc = pair_acc + ACC_W'(COEF[k] *
                       (ACC_W'(dly_r[CENTRE_DLY - k]) + ACC_W'(dly_r[CENTRE_DLY + 1 + k])));
        end
    end

    // centre tap 0.5 times interpolation gain 2 is unity; high-pass flips its sign
    always_comb begin
        centre_acc = ACC_W'(dly_r[CENTRE_DLY]) <<< FRAC_W;
        if (hp_r) begin
            centre_acc = -centre_acc;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    // word captured on the edge that ends the take cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            for (int i = 0; i < DLY_LEN; i++) dly_r[i] <= '0;
        end else if (mode_chg) begin
            // a word taken in the change cycle is kept, else the fill count overruns
            dly_r[0] <= take ? to_signed(DATA_IN) : '0;
            for (int i = 1; i < DLY_LEN; i++) dly_r[i] <= '0;
        end else if (take) begin
            dly_r[0] <= to_signed(DATA_IN);
            for (int i = 1; i < DLY_LEN; i++) dly_r[i] <= dly_r[i-1];
        end
    end

    // both polyphase outputs formed once per input sample
    always_ff @(posedge CLK) begin
        if (SRST) begin
            even_r <= MIDSCALE;
            odd_r  <= MIDSCALE;
        end else if (calc) begin
            even_r <= round_sat(pair_acc);
            odd_r  <= round_sat(centre_acc);
        end
    end

    // modes are sampled every cycle; a change restarts the fill count
    always_ff @(posedge CLK) begin
        if (SRST) begin
            hp_r    <= 1'b0;
            zs_r    <= 1'b0;
            flush_r <= 5'h00;
        end else begin
            hp_r <= FILTER_RESPONSE_SELECT;
            zs_r <= ZERO_INSERT_ENABLE;
            if (mode_chg) begin
                flush_r <= 5'h00;
            end else if (calc && !flushed) begin
                flush_r <= flush_r + 5'h01;
            end
        end
    end

    // hp with stuffing gives +x,0,-x,0 on the centre: the data-rate square-wave mix
    zero_stuff_mux u_mux (
        .clk       (CLK),
        .srst      (SRST),
        .even_smp  (even_r),
        .odd_smp   (odd_r),
        .smp_ok    (flushed),
        .slot      (slot),
        .zero_ins  (zs_r),
        .dac_data  (DAC_DATA),
        .dac_valid (DAC_VALID)
    );

    assign DATA_TAKE = take & ~SRST;

endmodule // halfband_interp_zero_stuff

/* File: test/hbi_monitor.sv */
// Purpose: port checker for the half-band interpolator
// Assumes: mode pins may change in any cycle, take cycles included
// Notes:   flush window bounds allow for the one-cycle mode register
`timescale 1ns/1ps
module hbi_monitor
    import hbi_pkg::*;
(
    // clock and reset
    input wire logic              CLK,
    input wire logic              SRST,
    // source and modes
    input wire logic [DATA_W-1:0] DATA_IN,
    input wire logic              DATA_TAKE,
    input wire logic              FILTER_RESPONSE_SELECT,
    input wire logic              ZERO_INSERT_ENABLE,
    // converter side
    input wire logic [DATA_W-1:0] DAC_DATA,
    input wire logic              DAC_VALID
);
    logic [7:0] lo_r;
    wire  [7:0] lo_nxt = (DAC_VALID || lo_r == 8'hFF) ? 8'h00 : lo_r + 8'h01;
    always_ff @(posedge CLK) lo_r <= SRST ? 8'h00 : lo_nxt;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    chk_take_cadence: assert property (DATA_TAKE |=> !DATA_TAKE [*3] ##1 DATA_TAKE)
        else $error("take cadence broken");
    chk_take_release: assert property ($fell(SRST) |-> DATA_TAKE)
        else $error("no take after reset");
    chk_park_mid: assert property (!DAC_VALID |-> DAC_DATA == MIDSCALE)
        else $error("invalid output not parked");
    chk_stuff_mid: assert property (ZERO_INSERT_ENABLE [*4] ##0 (DATA_TAKE && DAC_VALID)
        |-> DAC_DATA == MIDSCALE ##2 DAC_DATA == MIDSCALE) else $error("midscale slot missing");
    chk_nostuff_hold: assert property ((!ZERO_INSERT_ENABLE) [*4] ##0 (DATA_TAKE && DAC_VALID)
        |-> $stable(DAC_DATA) ##2 $stable(DAC_DATA)) else $error("sample not held two slots");
    chk_mode_flush: assert property ($changed(FILTER_RESPONSE_SELECT)
        || $changed(ZERO_INSERT_ENABLE) |-> ##[1:3] !DAC_VALID) else $error("no flush");
    chk_flush_len: assert property ($rose(DAC_VALID) |-> lo_r >= 8'h50 && lo_r <= 8'h60)
        else $error("flush length wrong");
    chk_valid_bound: assert property ($fell(SRST) |-> ##[1:100] DAC_VALID)
        else $error("valid late after reset");
endmodule // hbi_monitor
bind halfband_interp_zero_stuff hbi_monitor u_mon (.CLK(CLK), .SRST(SRST), .DATA_IN(DATA_IN),
    .DATA_TAKE(DATA_TAKE), .FILTER_RESPONSE_SELECT(FILTER_RESPONSE_SELECT),
    .ZERO_INSERT_ENABLE(ZERO_INSERT_ENABLE), .DAC_DATA(DAC_DATA), .DAC_VALID(DAC_VALID));

/* File: test/sample_source.sv */
// Purpose: external sample source model
// Assumes: one fresh word every clock, only take cycles matter
// Notes:   an eighth of words are full-scale to reach saturation
`timescale 1ns/1ps
module sample_source
    import hbi_pkg::*;
#(
    parameter logic [15:0] SEED = 16'hB59E
)
(
    // clock and word
    input  wire logic              clk,
    output logic      [DATA_W-1:0] data
);
    logic [15:0] s_r = SEED;
    initial data = MIDSCALE;
    function automatic logic [15:0] xs(input logic [15:0] v);
        logic [15:0] t;
        t = v ^ (v << 7);
        t = t ^ (t >> 9);
        return t ^ (t << 8);
    endfunction
    // change on falling edge so the word is settled at the take edge
    always @(negedge clk) begin
        s_r = xs(s_r);
        data <= (s_r[15:13] == 3'h0) ? {DATA_W{s_r[0]}} : s_r[DATA_W-1:0];
    end
endmodule // sample_source

/* File: test/tb_halfband_interp_zero_stuff.sv */
// Purpose: self-checking bench with integer filter model
// Assumes: even output pairs straddle the point between dl[10] and dl[11]
// Notes:   checks start once the delay line is surely refilled
`timescale 1ns/1ps
module tb_halfband_interp_zero_stuff;
    import hbi_pkg::*;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              fsel = 1'b0;
    logic              zins = 1'b0;
    logic [DATA_W-1:0] din, dac;
    logic              take, vld;
    int fails = 0, n_tests = 0, k = 0, nt = 0, acc = 0, ce = 0, co = 0, pe = 0, po = 0;
    int dl[$];
    always #10 clk = ~clk;
    sample_source u_src (.clk(clk), .data(din));
    halfband_interp_zero_stuff u_dut (.CLK(clk), .SRST(srst), .DATA_IN(din), .DATA_TAKE(take),
        .FILTER_RESPONSE_SELECT(fsel), .ZERO_INSERT_ENABLE(zins), .DAC_DATA(dac), .DAC_VALID(vld));
    function automatic int sat(input int v);
        return v > 8191 ? 8191 : (v < -8192 ? -8192 : v);
    endfunction
    task automatic cmpd(input string nm, input int e, input logic [DATA_W-1:0] got);
        n_tests++;
        if (got !== DATA_W'(e + 8192)) begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, DATA_W'(e + 8192), got);
        end
    endtask
    task automatic cmp1(input string nm, input logic e, input logic got);
        n_tests++;
        if (got !== e) begin
            fails++;
            $display("wrong value %s exp %b got %b", nm, e, got);
        end
    endtask
    always @(posedge clk) begin
        k = take ? 0 : k + 1;
        if (take === 1'b1) begin
            nt++;
            dl.push_front(int'(din) - 8192);
            if (dl.size() > DLY_LEN) void'(dl.pop_back());
            if (dl.size() == DLY_LEN) begin
                acc = 0;
                for (int i = 0; i < NPAIRS; i++) acc += int'(COEF[i]) * (dl[10-i] + dl[11+i]);
                pe = ce;
                po = co;
                ce = sat((acc + 16384) >>> 15);
                co = sat(fsel ? -dl[10] : dl[10]);
            end
        end
    end
    always @(negedge clk) begin
        if (!srst && nt >= 25) begin
            cmp1("valid", 1'b1, vld);
            case (k)
                2: cmpd("even", ce, dac);
                3: cmpd("slot1", zins ? 0 : ce, dac);
                0: cmpd("odd", po, dac);
                1: cmpd("slot3", zins ? 0 : po, dac);
                default: ;
            endcase
        end
    end
    task automatic run(input logic f, input logic z, input int n, input int at);
        do @(negedge clk); while (k != at);
        fsel = f;
        zins = z;
        nt = 0;
        repeat (n * 4) @(negedge clk);
        $display("test fsel=%0d zins=%0d done", f, z);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        for (int m = 0; m < 4; m++) run(m[0], m[1], 30, 2);
        srst = 1'b1;
        nt = 0;
        repeat (4) @(negedge clk);
        srst = 1'b0;
        run(1'b1, 1'b1, 30, 2);
        run(1'b0, 1'b1, 30, 3);
        wrap_up;
    end
    // whole run is about 800 cycles
    initial begin
        #(20 * 3000);
        fails++;
        wrap_up;
    end
endmodule // tb_halfband_interp_zero_stuff
